// File: core/vpd_voice_path.v
// voice path processing: tx/rx chains, answer tone detect, interrupt status
`timescale 1ns/100ps
`default_nettype none
`include "vpd_consts.vh"
module vpd_voice_path (
  // clock and reset
  input wire clk,
  input wire reset,
  // pcm highway clock and frame, from outside the clock domain
  input wire pcm_bit_clk,
  input wire pcm_frame_sync,
  // tx converter samples
  input wire tx_adc_valid,
  input wire [15:0] tx_adc_data,
  // tx highway bytes, one or two per frame
  output wire tx_pcm_valid,
  input wire tx_pcm_ready,
  output wire [7:0] tx_pcm_data,
  // rx highway bytes
  input wire rx_pcm_valid,
  input wire [7:0] rx_pcm_data,
  // rx converter samples
  output reg rx_dac_valid,
  output reg [15:0] rx_dac_data,
  // digit decoder tap and result
  input wire tone_digit_enable,
  output reg tone_digit_tap_valid,
  output reg [15:0] tone_digit_tap_data,
  input wire tone_digit_found,
  input wire [3:0] tone_digit_index,
  output reg [3:0] tone_digit_code,
  // control
  input wire [15:0] tx_gain_coeff,
  input wire [15:0] rx_gain_coeff,
  input wire tx_digital_mute,
  input wire rx_digital_mute,
  input wire compand_enable,
  input wire compand_alaw,
  input wire expansion_bypass_bit,
  input wire ans_tx_enable,
  input wire ans_rx_enable,
  input wire [3:0] ans_debounce_steps,
  // tone status
  output reg ans_tx_detected,
  output reg ans_rx_detected,
  // interrupts
  input wire [15:0] irq_event,
  input wire [15:0] irq_mask_regs,
  input wire [1:0] irq_read_sel,
  input wire irq_read,
  output reg [7:0] irq_read_data,
  output wire irq_n
);
  reg [15:0] irq_pending_regs;
  reg [2:0] bclk_sync_reg;
  reg [2:0] fsync_sync_reg;
  reg bclk_state_reg;
  reg fsync_state_reg;
  wire frame_start;
  // three-stage sync, change counted when stages two and three agree
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      bclk_sync_reg <= 3'h0;
      fsync_sync_reg <= 3'h0;
      bclk_state_reg <= 1'b0;
      fsync_state_reg <= 1'b0;
    end else begin
      bclk_sync_reg <= {bclk_sync_reg[1:0], pcm_bit_clk};
      fsync_sync_reg <= {fsync_sync_reg[1:0], pcm_frame_sync};
      if (bclk_sync_reg[1] == bclk_sync_reg[2]) bclk_state_reg <= bclk_sync_reg[2];
      if (fsync_sync_reg[1] == fsync_sync_reg[2]) fsync_state_reg <= fsync_sync_reg[2];
    end
  end
  // frame start marks one 8 kHz sample period
  assign frame_start = fsync_sync_reg[1] & fsync_sync_reg[2] & ~fsync_state_reg;

  // saturating q14 multiply shared by both gain stages
  function [15:0] gain_mul;
    input [15:0] s;
    input [15:0] g;
    reg signed [32:0] p;
    reg signed [32:0] q;
    begin
      p = $signed({{17{s[15]}}, s}) * $signed({17'h0, g});
      q = p >>> `VPD_UNITY_SHIFT;
      if (q > $signed({18'h0, `VPD_POS_FULL}))
        gain_mul = `VPD_POS_FULL;
      else if (q < -$signed({17'h0, `VPD_NEG_FULL}))
        gain_mul = `VPD_NEG_FULL;
      else
        gain_mul = q[15:0];
    end
  endfunction

  // simplified segment compander, alaw inverts even bits
  function [7:0] compress;
    input [15:0] s;
    input alaw;
    reg [15:0] m;
    reg [2:0] e;
    reg [3:0] f;
    integer i;
    begin
      m = s[15] ? (~s + 16'h0001) : s;
      if (m[15]) m = `VPD_POS_FULL;
      e = 3'h0;
      for (i = 8; i < 15; i = i + 1) begin
        if (m[i]) e = i[2:0] - 3'h7;
      end
      // index widened so segments above four do not wrap to the bottom bits
      f = (e == 3'h0) ? m[7:4] : m[({1'b0, e} + 4'h3) +: 4];
      compress = {~s[15], e, f} ^ (alaw ? 8'h55 : 8'hff);
    end
  endfunction

  function [15:0] expand;
    input [7:0] c;
    input alaw;
    reg [7:0] d;
    reg [15:0] m;
    begin
      d = c ^ (alaw ? 8'h55 : 8'hff);
      if (d[6:4] == 3'h0) m = {8'h0, d[3:0], 4'h8};
      else m = {11'h0, 1'b1, d[3:0]} << ({1'b0, d[6:4]} + 4'h3);
      expand = d[7] ? m : (~m + 16'h0001);
    end
  endfunction

  reg signed [31:0] hpf_dc_reg;
  reg [15:0] hpf_out_reg;
  reg [15:0] eq_prev_reg;
  reg [15:0] eq_out_reg;
  reg tx_stage_reg;
  wire signed [31:0] hpf_diff;
  assign hpf_diff = $signed({{16{tx_adc_data[15]}}, tx_adc_data}) -
                    (hpf_dc_reg >>> `VPD_HPF_SHIFT);
  // leaky dc tracker; corner near 5 Hz keeps deep stopband in 16 bits
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hpf_dc_reg <= 32'h0;
      hpf_out_reg <= 16'h0;
      eq_prev_reg <= 16'h0;
      eq_out_reg <= 16'h0;
      tx_stage_reg <= 1'b0;
    end else begin
      tx_stage_reg <= tx_adc_valid;
      // one linear word per sample period
      if (tx_adc_valid) begin
        hpf_dc_reg <= hpf_dc_reg + hpf_diff;
        hpf_out_reg <= hpf_diff[15:0];
        eq_prev_reg <= hpf_out_reg;
        // equaliser lifts highs lost in protection resistance
        // signed throughout, so a falling slope shifts arithmetically
        eq_out_reg <= $signed(hpf_out_reg) +
                      ($signed(hpf_out_reg - eq_prev_reg) >>> `VPD_EQ_SHIFT);
      end
    end
  end

  // tx gain, digit tap and highway packing
  wire [15:0] tx_gain_eff;
  wire [15:0] tx_lin;
  wire [7:0] tx_comp;
  wire fifo_in_ready;
  reg tx_push_reg;
  reg tx_second_reg;
  reg [7:0] tx_byte_reg;
  reg [7:0] tx_low_reg;
  // mute gates the coefficient, stored value untouched
  assign tx_gain_eff = tx_digital_mute ? 16'h0 : tx_gain_coeff;
  assign tx_lin = gain_mul(eq_out_reg, tx_gain_eff);
  assign tx_comp = compress(tx_lin, compand_alaw);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      tone_digit_tap_valid <= 1'b0;
      tone_digit_tap_data <= 16'h0;
      tx_push_reg <= 1'b0;
      tx_second_reg <= 1'b0;
      tx_byte_reg <= 8'h0;
      tx_low_reg <= 8'h0;
    end else begin
      tone_digit_tap_valid <= tx_stage_reg & tone_digit_enable;
      if (tx_stage_reg) tone_digit_tap_data <= tx_lin;
      if (tx_push_reg & fifo_in_ready) begin
        // second slot of a linear word follows the first
        tx_push_reg <= tx_second_reg;
        tx_byte_reg <= tx_low_reg;
        tx_second_reg <= 1'b0;
      end else if (tx_stage_reg & ~tx_push_reg) begin
        // one slot compressed, two slots linear
        tx_push_reg <= 1'b1;
        tx_byte_reg <= compand_enable ? tx_comp : tx_lin[15:8];
        tx_low_reg <= tx_lin[7:0];
        tx_second_reg <= ~compand_enable;
      end
    end
  end
  // fifo back-pressure stalls the packer above
  vpd_fifo #(.WIDTH(8), .DEPTH(`VPD_FIFO_DEPTH), .AW(3)) u_tx_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(tx_push_reg),
    .in_ready(fifo_in_ready),
    .in_data(tx_byte_reg),
    .out_valid(tx_pcm_valid),
    .out_ready(tx_pcm_ready),
    .out_data(tx_pcm_data)
  );

  // rx byte assembly and gain
  reg rx_state_reg;
  reg [7:0] rx_hi_reg;
  reg [15:0] rx_word_reg;
  reg rx_word_valid_reg;
  wire [15:0] rx_gain_eff;
  assign rx_gain_eff = rx_digital_mute ? 16'h0 : rx_gain_coeff;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_state_reg <= `VPD_ST_BYTE_HI;
      rx_hi_reg <= 8'h0;
      rx_word_reg <= 16'h0;
      rx_word_valid_reg <= 1'b0;
      rx_dac_valid <= 1'b0;
      rx_dac_data <= 16'h0;
    end else begin
      rx_word_valid_reg <= 1'b0;
      if (frame_start) rx_state_reg <= `VPD_ST_BYTE_HI;
      // expand, or pair bytes high first under bypass
      if (rx_pcm_valid) begin
        case (rx_state_reg)
          `VPD_ST_BYTE_HI: begin
            if (expansion_bypass_bit) begin
              rx_hi_reg <= rx_pcm_data;
              rx_state_reg <= `VPD_ST_BYTE_LO;
            end else begin
              rx_word_reg <= expand(rx_pcm_data, compand_alaw);
              rx_word_valid_reg <= 1'b1;
            end
          end
          `VPD_ST_BYTE_LO: begin
            rx_word_reg <= {rx_hi_reg, rx_pcm_data};
            rx_word_valid_reg <= 1'b1;
            rx_state_reg <= `VPD_ST_BYTE_HI;
          end
          default: rx_state_reg <= `VPD_ST_BYTE_HI;
        endcase
      end
      // saturated 16-bit sample to the converter
      rx_dac_valid <= rx_word_valid_reg;
      if (rx_word_valid_reg) rx_dac_data <= gain_mul(rx_word_reg, rx_gain_eff);
    end
  end

  // digit code map, d wraps to zero
  always @(posedge clk or posedge reset) begin
    if (reset) tone_digit_code <= 4'h0;
    else if (tone_digit_found) tone_digit_code <= tone_digit_index + 4'h1;
  end

  // answer tone detectors: zero-crossing period check plus debounce
  wire [15:0] ans_sample [0:1];
  wire ans_valid [0:1];
  wire ans_en [0:1];
  wire [1:0] ans_hit;
  assign ans_sample[0] = tx_lin;
  assign ans_valid[0] = tx_stage_reg;
  assign ans_en[0] = ans_tx_enable;
  assign ans_sample[1] = rx_word_reg;
  assign ans_valid[1] = rx_word_valid_reg;
  assign ans_en[1] = ans_rx_enable;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ans
      reg sign_reg;
      reg [31:0] gap_reg;
      reg [39:0] hold_reg;
      reg found_reg;
      wire near_tone;
      // sampled crossings alias, so check crossing rate per half period
      assign near_tone = (gap_reg + `VPD_TONE_TOL_CYC > `VPD_TONE_HALF_CYC) &&
                         (gap_reg < `VPD_TONE_HALF_CYC + `VPD_TONE_TOL_CYC);
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          sign_reg <= 1'b0;
          gap_reg <= 32'h0;
          hold_reg <= 40'h0;
          found_reg <= 1'b0;
        end else if (!ans_en[gi]) begin
          // idle while disabled; host turns it off to save power
          gap_reg <= 32'h0;
          hold_reg <= 40'h0;
          found_reg <= 1'b0;
        end else begin
          gap_reg <= gap_reg + 32'h1;
          if (hold_reg != 40'h0) hold_reg <= hold_reg + 40'h1;
          if (ans_valid[gi] && sign_reg != ans_sample[gi][15]) begin
            sign_reg <= ans_sample[gi][15];
            gap_reg <= 32'h0;
            if (!near_tone) hold_reg <= 40'h0;
            else if (hold_reg == 40'h0) hold_reg <= 40'h1;
          end
          // tone must last the programmed 67 ms steps
          if (hold_reg >= ans_debounce_steps * `VPD_DEBOUNCE_STEP_CYC && hold_reg != 40'h0)
            found_reg <= 1'b1;
        end
      end
      assign ans_hit[gi] = found_reg;
    end
  endgenerate
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ans_tx_detected <= 1'b0;
      ans_rx_detected <= 1'b0;
    end else begin
      ans_tx_detected <= ans_hit[0];
      ans_rx_detected <= ans_hit[1];
    end
  end

  // interrupt status, two readable bytes
  reg [1:0] ans_hit_d_reg;
  wire [15:0] irq_src;
  wire [15:0] irq_clear;
  always @(posedge clk or posedge reset) begin
    if (reset) ans_hit_d_reg <= 2'h0;
    else ans_hit_d_reg <= ans_hit;
  end
  // sixteen sources, tone and digit events merged in
  assign irq_src = irq_event |
    ({15'h0, tone_digit_found} << `VPD_IRQ_DIGIT) |
    ({15'h0, ans_hit[1] & ~ans_hit_d_reg[1]} << `VPD_IRQ_ANS_RX) |
    ({15'h0, ans_hit[0] & ~ans_hit_d_reg[0]} << `VPD_IRQ_ANS_TX);
  assign irq_clear = !irq_read ? 16'h0 :
    (irq_read_sel == 2'h0) ? 16'h00ff :
    (irq_read_sel == 2'h1) ? 16'hff00 : 16'h0;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_pending_regs <= 16'h0;
      irq_read_data <= 8'h0;
    end else begin
      irq_pending_regs <= (irq_pending_regs & ~irq_clear) | (irq_src & irq_mask_regs);
      if (irq_read) begin
        case (irq_read_sel)
          2'h0: irq_read_data <= irq_pending_regs[7:0];
          2'h1: irq_read_data <= irq_pending_regs[15:8];
          default: irq_read_data <= 8'h0;
        endcase
      end
    end
  end
  // active-low nor of all pending bits
  assign irq_n = ~|irq_pending_regs;
endmodule
`default_nettype wire

// File: core/vpd_consts.vh
// constants for the voice path processing block
`ifndef VPD_CONSTS_VH
`define VPD_CONSTS_VH
`define VPD_CLK_MHZ 250
`define VPD_DEBOUNCE_STEP_MS 67
`define VPD_DEBOUNCE_STEP_CYC (`VPD_DEBOUNCE_STEP_MS * 1000 * `VPD_CLK_MHZ)
`define VPD_TONE_HZ 2100
`define VPD_TONE_HALF_CYC ((`VPD_CLK_MHZ * 1000000) / (2 * `VPD_TONE_HZ))
`define VPD_TONE_TOL_CYC 32'd2000
`define VPD_UNITY_SHIFT 14
`define VPD_GAIN_UNITY 16'h4000
`define VPD_POS_FULL 16'h7fff
`define VPD_NEG_FULL 16'h8000
`define VPD_HPF_SHIFT 8
`define VPD_EQ_SHIFT 3
`define VPD_NUM_IRQ 16
`define VPD_IRQ_WORDS 3
`define VPD_IRQ_ANS_RX 14
`define VPD_IRQ_ANS_TX 15
`define VPD_IRQ_DIGIT 4
`define VPD_FIFO_DEPTH 8
`define VPD_SYNC_DEPTH 3
`define VPD_ST_BYTE_HI 1'b0
`define VPD_ST_BYTE_LO 1'b1
`endif

// File: core/vpd_fifo.v
// parameterised sample fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module vpd_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire push;
  wire pop;
  // full when pointers differ only in wrap bit
  assign in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  // storage has no reset, pointers do
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  // pointer update
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: tb/vpd_voice_path_asserts.sv
// concurrent checks on the voice path ports
`timescale 1ns/100ps
`default_nettype none
module vpd_voice_path_asserts (
  // clock and reset
  input wire clk,
  input wire reset,
  // tx side
  input wire tx_adc_valid,
  input wire tx_digital_mute,
  input wire [15:0] tx_gain_coeff,
  input wire tone_digit_tap_valid,
  input wire [15:0] tone_digit_tap_data,
  // rx side
  input wire rx_digital_mute,
  input wire rx_dac_valid,
  input wire [15:0] rx_dac_data,
  // tone status
  input wire ans_tx_enable,
  input wire ans_rx_enable,
  input wire ans_tx_detected,
  input wire ans_rx_detected,
  // interrupts
  input wire [15:0] irq_event,
  input wire [15:0] irq_mask_regs,
  input wire [1:0] irq_read_sel,
  input wire irq_read,
  input wire [7:0] irq_read_data,
  input wire irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // masked event on bit 0, and a low byte read
  sequence ev0;
    irq_event[0] && irq_mask_regs[0];
  endsequence
  sequence rd0;
    irq_read && irq_read_sel == 2'd0;
  endsequence
  // low byte read with the low mask off long enough that no event is in flight
  sequence rd0_quiet;
    rd0 ##0 (irq_mask_regs[7:0] == 8'h00 && $past(irq_mask_regs[7:0]) == 8'h00);
  endsequence
  // bits 4, 14 and 15 come from inside, so only the outside sources count here
  irq_set_a: assert property ((irq_event & irq_mask_regs & 16'h3fef) != 16'h0 |=> !irq_n)
    else $error("pin idle after masked event");
  irq_quiet_a: assert property (irq_n && irq_mask_regs == 16'h0 && $past(irq_mask_regs) == 16'h0 |=> irq_n)
    else $error("pin fell with all masks off");
  read_return_a: assert property (ev0 ##1 rd0 |=> irq_read_data[0])
    else $error("pending bit missing from read");
  same_cycle_a: assert property (rd0 ##0 ev0 |=> !irq_n)
    else $error("event lost under clearing read");
  read_clear_a: assert property (rd0_quiet ##1 rd0_quiet |=> irq_read_data == 8'h00)
    else $error("read did not clear");
  tap_lat_a: assert property (tone_digit_tap_valid |-> $past(tx_adc_valid, 2))
    else $error("tap without sample");
  tx_mute_a: assert property (tone_digit_tap_valid && ($past(tx_gain_coeff) == 16'h0 || $past(tx_digital_mute)) |-> tone_digit_tap_data == 16'h0)
    else $error("tx not silenced");
  rx_mute_a: assert property (rx_dac_valid && $past(rx_digital_mute) |-> rx_dac_data == 16'h0)
    else $error("rx not silenced");
  ans_tx_a: assert property ($rose(ans_tx_detected) |-> $past(ans_tx_enable, 2))
    else $error("tx tone flagged while off");
  ans_rx_a: assert property ($rose(ans_rx_detected) |-> $past(ans_rx_enable, 2))
    else $error("rx tone flagged while off");
endmodule
bind vpd_voice_path vpd_voice_path_asserts chk (.*);
`default_nettype wire

// File: tb/vpd_pcm_partner.sv
// pcm highway side: bit clock, frame start and a slow byte sink
`timescale 1ns/100ps
`default_nettype none
module vpd_pcm_partner (
  // system clock
  input wire clk,
  // highway timing
  output logic pcm_bit_clk,
  output wire pcm_frame_sync,
  // tx byte sink
  input wire tx_pcm_valid,
  output logic tx_pcm_ready,
  input wire [7:0] tx_pcm_data,
  // bench control and tallies
  input wire stall,
  output logic [15:0] byte_count,
  output logic [7:0] or_bytes
);
  logic [4:0] bit_cnt = 5'h0;
  // the highway clock runs free, frames or not
  initial begin
    pcm_bit_clk = 1'b0;
    forever #24 pcm_bit_clk = ~pcm_bit_clk;
  end
  // one frame start every 32 bit clocks
  always @(posedge pcm_bit_clk) bit_cnt <= bit_cnt + 5'h1;
  assign pcm_frame_sync = (bit_cnt == 5'h0);
  // ready only every other cycle, so the block must hold its byte
  initial begin
    tx_pcm_ready = 1'b0;
    byte_count = 16'h0;
    or_bytes = 8'h0;
  end
  always @(posedge clk) begin
    if (tx_pcm_valid && tx_pcm_ready) begin
      byte_count <= byte_count + 16'h1;
      or_bytes <= or_bytes | tx_pcm_data;
    end
    tx_pcm_ready <= #1 !stall && !tx_pcm_ready;
  end
endmodule
`default_nettype wire

// File: tb/voice_path_dsp_with_irq_bench.sv
// self-checking bench for the voice path block
`timescale 1ns/100ps
`default_nettype none
module voice_path_dsp_with_irq_bench;
  logic clk = 0, reset = 1, stall = 0;
  logic tx_adc_valid = 0, rx_pcm_valid = 0, tone_digit_enable = 0, tone_digit_found = 0;
  logic [15:0] tx_adc_data = 0, tx_gain_coeff = 16'h4000, rx_gain_coeff = 16'h4000;
  logic [7:0] rx_pcm_data = 0;
  logic [3:0] tone_digit_index = 0, ans_debounce_steps = 0;
  logic tx_digital_mute = 0, rx_digital_mute = 0, compand_enable = 0, compand_alaw = 0;
  logic expansion_bypass_bit = 1, ans_tx_enable = 0, ans_rx_enable = 0, irq_read = 0;
  logic [15:0] irq_event = 0, irq_mask_regs = 0;
  logic [1:0] irq_read_sel = 0;
  wire pcm_bit_clk, pcm_frame_sync, tx_pcm_valid, tx_pcm_ready, rx_dac_valid, irq_n;
  wire tone_digit_tap_valid, ans_tx_detected, ans_rx_detected;
  wire [7:0] tx_pcm_data, irq_read_data, or_bytes;
  wire [15:0] rx_dac_data, tone_digit_tap_data, byte_count;
  wire [3:0] tone_digit_code;
  int fails = 0, cmp_count = 0, cyc = 0;
  vpd_voice_path uut (.*);
  vpd_pcm_partner hwy (.clk, .pcm_bit_clk, .pcm_frame_sync, .tx_pcm_valid, .tx_pcm_ready,
    .tx_pcm_data, .stall, .byte_count, .or_bytes);
  // 4 ns clock; inputs move 1 ns after each rising edge
  always #2 clk = ~clk;
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, well above the roughly 75000 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      close_out();
    end
  end
  // masking, pin, clear on read, event racing the read
  task automatic t_irq();
    irq_mask_regs = 16'h00fe;
    irq_event = 16'h0101;
    step(1);
    irq_event = 0;
    step(1);
    chk("irq_n masked", 16'h1, irq_n);
    irq_mask_regs = 16'hffef;
    irq_event = 16'h0205;
    step(1);
    chk("irq_n set", 16'h0, irq_n);
    irq_read = 1;
    irq_event = 16'h0001;
    step(1);
    irq_event = 0;
    chk("low byte", 16'h05, irq_read_data);
    step(1);
    chk("racing event", 16'h01, irq_read_data);
    irq_read_sel = 1;
    step(1);
    irq_read = 0;
    chk("high byte", 16'h02, irq_read_data);
    chk("irq_n clear", 16'h1, irq_n);
    $display("irq test done");
  endtask
  // every digit index, then the digit interrupt
  task automatic t_digit();
    // expected code per index, digits in order 1-9, 0, star, pound, A-D
    logic [63:0] codes = 64'h0fedcba987654321;
    irq_mask_regs = 16'h0010;
    tone_digit_enable = 1;
    irq_read_sel = 0;
    for (int i = 0; i < 16; i++) begin
      tone_digit_index = i[3:0];
      tone_digit_found = 1;
      step(1);
      tone_digit_found = 0;
      step(3);
      chk("digit code", {12'h0, codes[4*i +: 4]}, tone_digit_code);
    end
    chk("digit irq_n", 16'h0, irq_n);
    irq_read = 1;
    step(1);
    irq_read = 0;
    chk("digit bit", 16'h10, irq_read_data);
    irq_mask_regs = 0;
    step(2);
    irq_read = 1;
    step(2);
    irq_read = 0;
    chk("empty read", 16'h0, irq_read_data);
    $display("digit test done");
  endtask
  // fifo filled against a stalled highway, then drained
  task automatic t_tx();
    logic [15:0] n0;
    n0 = byte_count;
    tx_gain_coeff = 16'h0000;
    ans_tx_enable = 1;
    stall = 1;
    repeat (6) begin
      tx_adc_data = 16'h7fff;
      tx_adc_valid = 1;
      step(1);
      tx_adc_valid = 0;
      step(9);
    end
    chk("stalled valid", 16'h1, tx_pcm_valid);
    stall = 0;
    step(60);
    chk("drained", 16'h0, tx_pcm_valid);
    chk("muted bytes", 16'h0, or_bytes);
    chk("whole words", 16'h0, (byte_count - n0) & 16'h1);
    chk("fifo depth", 16'h1, (byte_count - n0) >= 16'd8);
    chk("no tone", 16'h0, ans_tx_detected);
    // detector switched off once the tone window is over
    ans_tx_enable = 0;
    $display("tx test done");
  endtask
  // byte pairs through the rx gain: unity, zero, mute, half, both limits
  task automatic t_rx();
    logic [15:0] w [6] = '{16'h1234, 16'h1234, 16'h1234, 16'h1234, 16'h7000, 16'h9000};
    logic [15:0] g [6] = '{16'h4000, 16'h0000, 16'h4000, 16'h2000, 16'h7fff, 16'h7fff};
    logic [15:0] e [6] = '{16'h1234, 16'h0000, 16'h0000, 16'h091a, 16'h7fff, 16'h8000};
    logic [5:0] m = 6'b000100;
    // a stray byte that the next frame start must discard
    rx_pcm_data = 8'haa;
    rx_pcm_valid = 1;
    step(1);
    rx_pcm_valid = 0;
    for (int i = 0; i < 6; i++) begin
      rx_gain_coeff = g[i];
      rx_digital_mute = m[i];
      @(posedge pcm_frame_sync);
      step(8);
      rx_pcm_data = w[i][15:8];
      rx_pcm_valid = 1;
      step(1);
      rx_pcm_valid = 0;
      step(1);
      rx_pcm_data = w[i][7:0];
      rx_pcm_valid = 1;
      step(1);
      rx_pcm_valid = 0;
      for (int k = 0; k < 8; k++) if (!rx_dac_valid) step(1);
      chk("rx sample", e[i], rx_dac_data);
    end
    // expand mode: one companded byte makes one sample
    expansion_bypass_bit = 0;
    rx_gain_coeff = 16'h4000;
    rx_digital_mute = 0;
    rx_pcm_data = 8'h2a;
    rx_pcm_valid = 1;
    step(1);
    rx_pcm_valid = 0;
    for (int k = 0; k < 8; k++) if (!rx_dac_valid) step(1);
    chk("rx expand", 16'h1500, rx_dac_data);
    expansion_bypass_bit = 1;
    $display("rx test done");
  endtask
  // a steady level passes, then fades through the high-pass; one compressed slot
  task automatic t_hpf();
    logic [15:0] n0;
    tx_gain_coeff = 16'h4000;
    tx_adc_data = 16'h1000;
    for (int n = 0; n < 2000; n++) begin
      tx_adc_valid = 1;
      step(1);
      tx_adc_valid = 0;
      step(5);
      if (n == 3) chk("dc passes", 16'h1, $signed(tone_digit_tap_data) > 16'sh0800);
    end
    chk("dc removed", 16'h1, $signed(tone_digit_tap_data) < 16 && $signed(tone_digit_tap_data) > -16);
    step(10);
    n0 = byte_count;
    compand_enable = 1;
    tx_adc_valid = 1;
    step(1);
    tx_adc_valid = 0;
    step(20);
    compand_enable = 0;
    chk("one slot", 16'h1, byte_count - n0);
    $display("hpf test done");
  endtask
  // rx answer tone: one in-band crossing, no debounce, then switched off
  task automatic t_tone();
    ans_debounce_steps = 0;
    irq_mask_regs = 16'h4000;
    ans_rx_enable = 1;
    step(59000);
    @(posedge pcm_frame_sync);
    step(8);
    rx_pcm_data = 8'h80;
    rx_pcm_valid = 1;
    step(1);
    rx_pcm_data = 8'h00;
    step(1);
    rx_pcm_valid = 0;
    step(4);
    chk("rx tone", 16'h1, ans_rx_detected);
    chk("tone irq_n", 16'h0, irq_n);
    irq_read_sel = 1;
    irq_read = 1;
    step(1);
    irq_read = 0;
    chk("tone bit", 16'h40, irq_read_data);
    // detector off once the tone window is over
    ans_rx_enable = 0;
    step(3);
    chk("tone cleared", 16'h0, ans_rx_detected);
    $display("tone test done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    step(12);
    reset = 0;
    step(1);
    t_irq();
    t_digit();
    t_tx();
    t_hpf();
    t_rx();
    t_tone();
    close_out();
  end
endmodule
`default_nettype wire
